// ==== logic/pwmct_top.sv ====
// Eight-channel 8-bit PWM: prescaler, two scalers, channel timers and an
// AXI4-Lite register slave. Assumes one clock; freeze_in is asynchronous.
`include "pwmct_cfg.svh"

module pwmct_top (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 ce,
	input  wire logic                 freeze_in,
	input  wire pwmct_pkg::pwmct_addr_t awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire pwmct_pkg::pwmct_word_t wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output pwmct_pkg::pwmct_resp_t    bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire pwmct_pkg::pwmct_addr_t araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output pwmct_pkg::pwmct_word_t    rdata,
	output pwmct_pkg::pwmct_resp_t    rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	output wire pwmct_pkg::pwmct_chan_t pwm_out
);
	import pwmct_pkg::*;

	// Software-visible control
	pwmct_chan_t en_reg;
	pwmct_chan_t pol_reg;
	pwmct_chan_t scl_sel;
	pwmct_chan_t ab_sel;
	pwmct_chan_t calign;
	pwmct_byte_t ctrl_reg;
	pwmct_byte_t presc_reg;

	// Bus slave state
	logic        aw_full;
	logic        w_full;
	pwmct_addr_t aw_addr_q;
	pwmct_byte_t wdata_q;
	logic        wstrb_q;

	// Freeze synchroniser and prescaler
	logic        frz_s1;
	logic        frz_s2;
	logic [6:0]  pcnt;

	wire         presc_run;
	wire  [1:0]  btick;
	wire  [1:0]  stick;

	pwmct_byte_t cnt_rd   [8];
	pwmct_byte_t per_rd   [8];
	pwmct_byte_t dty_rd   [8];
	pwmct_byte_t scale_rd [2];

	// Write decode
	wire  [5:0]  wr_idx  = aw_addr_q[7:2];
	wire         wr_fire = ce & aw_full & w_full & ~bvalid;
	wire         wr_en   = wr_fire & wstrb_q;

	wire         wr_ok   = (wr_idx <= `PWMCT_IDX_ABSEL) ||
	                       (wr_idx == `PWMCT_IDX_SCALE_A) ||
	                       (wr_idx == `PWMCT_IDX_SCALE_B) ||
	                       ((wr_idx >= `PWMCT_IDX_CNT) &&
	                        (wr_idx <= `PWMCT_IDX_LAST));

	// Read decode
	wire  [5:0]  rd_idx  = araddr[7:2];
	wire  [5:0]  rd_coff = rd_idx - `PWMCT_IDX_CNT;
	wire  [5:0]  rd_poff = rd_idx - `PWMCT_IDX_PER;
	wire  [5:0]  rd_doff = rd_idx - `PWMCT_IDX_DTY;
	// Each range is eight wide, so the low three offset bits pick the channel

	wire         rd_cnt  = (rd_idx >= `PWMCT_IDX_CNT) &&
	                       (rd_idx <  `PWMCT_IDX_PER);
	wire         rd_per  = (rd_idx >= `PWMCT_IDX_PER) &&
	                       (rd_idx <  `PWMCT_IDX_DTY);
	wire         rd_dty  = (rd_idx >= `PWMCT_IDX_DTY) &&
	                       (rd_idx <= `PWMCT_IDX_LAST);

	wire         rd_ok   = (rd_idx <= `PWMCT_IDX_ABSEL) ||
	                       (rd_idx == `PWMCT_IDX_SCALE_A) ||
	                       (rd_idx == `PWMCT_IDX_SCALE_B) ||
	                       rd_cnt || rd_per || rd_dty;

	// Counter reads are plain taps on the count and have no side effect
	wire pwmct_byte_t rd_val =
		(rd_idx == `PWMCT_IDX_ENABLE)   ? en_reg :
		(rd_idx == `PWMCT_IDX_POLARITY) ? pol_reg :
		(rd_idx == `PWMCT_IDX_SCLSEL)   ? scl_sel :
		(rd_idx == `PWMCT_IDX_PRESC)    ? presc_reg :
		(rd_idx == `PWMCT_IDX_CALIGN)   ? calign :
		(rd_idx == `PWMCT_IDX_CTRL)     ? ctrl_reg :
		(rd_idx == `PWMCT_IDX_ABSEL)    ? ab_sel :
		(rd_idx == `PWMCT_IDX_SCALE_A)  ? scale_rd[0] :
		(rd_idx == `PWMCT_IDX_SCALE_B)  ? scale_rd[1] :
		rd_cnt                          ? cnt_rd[rd_coff[2:0]] :
		rd_per                          ? per_rd[rd_poff[2:0]] :
		rd_dty                          ? dty_rd[rd_doff[2:0]] :
		8'h00;

	// AXI4-Lite handshakes; one write and one read in flight at most
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b0;
			wready    <= 1'b0;
			arready   <= 1'b0;
			bvalid    <= 1'b0;
			rvalid    <= 1'b0;
			bresp     <= `PWMCT_RESP_OKAY;
			rresp     <= `PWMCT_RESP_OKAY;
			rdata     <= 32'h0000_0000;
			aw_full   <= 1'b0;
			w_full    <= 1'b0;
			aw_addr_q <= 8'h00;
			wdata_q   <= 8'h00;
			wstrb_q   <= 1'b0;
		end else if (ce) begin
			// Readies return only after the response is taken: one write at a time
			if (!awready && !aw_full && !bvalid) begin
				awready <= 1'b1;
			end
			if (!wready && !w_full && !bvalid) begin
				wready <= 1'b1;
			end
			if (!arready && !rvalid) begin
				arready <= 1'b1;
			end
			if (awvalid && awready) begin
				awready   <= 1'b0;
				aw_full   <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wready  <= 1'b0;
				w_full  <= 1'b1;
				wdata_q <= wdata[7:0];
				wstrb_q <= wstrb[0];
			end
			if (wr_fire) begin
				aw_full <= 1'b0;
				w_full  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_ok ? `PWMCT_RESP_OKAY : `PWMCT_RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= {24'h00_0000, rd_val};
				rresp   <= rd_ok ? `PWMCT_RESP_OKAY : `PWMCT_RESP_SLVERR;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Plain control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_reg    <= 8'h00;
			pol_reg   <= 8'h00;
			scl_sel   <= `PWMCT_RST_SCLSEL;
			ab_sel    <= `PWMCT_RST_ABSEL;
			calign    <= 8'h00;
			ctrl_reg  <= 8'h00;
			presc_reg <= 8'h00;
		end else if (wr_en) begin
			case (wr_idx)
				`PWMCT_IDX_ENABLE:   en_reg    <= wdata_q;
				`PWMCT_IDX_POLARITY: pol_reg   <= wdata_q;
				`PWMCT_IDX_SCLSEL:   scl_sel   <= wdata_q;
				`PWMCT_IDX_PRESC:    presc_reg <= wdata_q & 8'h77;
				`PWMCT_IDX_CALIGN:   calign    <= wdata_q;
				`PWMCT_IDX_CTRL:     ctrl_reg  <= wdata_q & 8'h04;
				`PWMCT_IDX_ABSEL:    ab_sel    <= wdata_q;
				default: ;
			endcase
		end
	end

	// Freeze comes from the chip level, so it is synchronised first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frz_s1 <= 1'b0;
			frz_s2 <= 1'b0;
		end else if (ce) begin
			frz_s1 <= freeze_in;
			frz_s2 <= frz_s1;
		end
	end

	// Freeze acts only while software has armed the gate bit
	wire         frz_gate = ctrl_reg[`PWMCT_CTRL_FRZ] & frz_s2;
	// All channels idle: stop the prescaler to save power
	wire         any_en   = |en_reg;

	assign presc_run = ~frz_gate & any_en;

	// One shared count feeds both dividers, so A and B stay in phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pcnt <= 7'h00;
		end else if (ce && presc_run) begin
			pcnt <= pcnt + 7'h01;
		end
	end

	// Clock A and B ticks, then the scaled SA and SB ticks
	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_scl
			wire  [2:0]  psel  = (k == 0) ?
			                     presc_reg[`PWMCT_PRESC_A_LSB +: 3] :
			                     presc_reg[`PWMCT_PRESC_B_LSB +: 3];
			wire  [6:0]  pmask = ~(7'h7F << psel);
			wire         w_scl = wr_en &&
			                     (wr_idx == 6'(`PWMCT_IDX_SCALE_A + k));
			pwmct_byte_t dcnt;
			pwmct_byte_t sval;
			logic        half;
			wire         pulse = btick[k] & (dcnt == 8'h01);

			// A divide by 2^n ticks when the low n prescale bits are ones
			assign btick[k]    = presc_run & ((pcnt & pmask) == pmask);
			assign stick[k]    = pulse & half;
			assign scale_rd[k] = sval;

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					dcnt <= 8'h00;
					sval <= 8'h00;
					half <= 1'b0;
				end else if (ce) begin
					// The divide-by-two flop is left alone, so SA may slip once
					if (w_scl) begin
						sval <= wdata_q;
						dcnt <= wdata_q;
					end else if (btick[k]) begin
						// A load of zero wraps through 255, so 256 ticks
						dcnt <= pulse ? sval : dcnt - 8'h01;
						if (pulse) begin
							half <= ~half;
						end
					end
				end
			end
		end
	endgenerate

	// Channel timers
	genvar i;
	generate
		for (i = 0; i < `PWMCT_NCH; i++) begin : g_ch
			pwmct_byte_t cnt;
			pwmct_byte_t per_buf;
			pwmct_byte_t per_act;
			pwmct_byte_t dty_buf;
			pwmct_byte_t dty_act;
			logic        dir_dn;
			logic        wave;
			logic        en_sync;
			logic        en_prev;
			logic        zero_pend;
			logic        po;

			wire         en       = en_reg[i];
			wire         tick_src = scl_sel[i] ? stick[ab_sel[i]] :
			                        btick[ab_sel[i]];
			wire         run      = en_sync & tick_src;
			wire         dis_edge = en_prev & ~en;
			wire         w_cnt    = wr_en &&
			                        (wr_idx == 6'(`PWMCT_IDX_CNT + i));
			wire         w_per    = wr_en &&
			                        (wr_idx == 6'(`PWMCT_IDX_PER + i));
			wire         w_dty    = wr_en &&
			                        (wr_idx == 6'(`PWMCT_IDX_DTY + i));
			wire pwmct_byte_t up_n = cnt + 8'h01;
			wire pwmct_byte_t dn_n = cnt - 8'h01;
			wire pwmct_byte_t nxt  = dir_dn ? dn_n : up_n;
			wire         per_hit  = ~dir_dn & (up_n == per_act);
			wire         zero_hit = dir_dn & (dn_n == 8'h00);
			wire         dty_hit  = (nxt == dty_act);
			wire         end_left = ~calign[i] & per_hit;
			wire         end_ctr  = calign[i] & zero_hit;

			assign cnt_rd[i]  = cnt;
			assign per_rd[i]  = per_buf;
			assign dty_rd[i]  = dty_buf;
			assign pwm_out[i] = po;

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cnt       <= 8'h00;
					per_buf   <= `PWMCT_RST_PER;
					per_act   <= `PWMCT_RST_PER;
					dty_buf   <= `PWMCT_RST_DTY;
					dty_act   <= `PWMCT_RST_DTY;
					dir_dn    <= 1'b0;
					wave      <= 1'b0;
					en_sync   <= 1'b0;
					en_prev   <= 1'b0;
					zero_pend <= 1'b0;
					po        <= 1'b0;
				end else if (ce) begin
					en_prev <= en;
					// Output pin follows enable at once, level from polarity
					po      <= en & (wave ^ pol_reg[i]);
					// Enable reaches the counter only on a tick, so none is cut short
					if (tick_src) begin
						en_sync <= en;
					end
					if (w_per) begin
						per_buf <= wdata_q;
					end
					if (w_dty) begin
						dty_buf <= wdata_q;
					end
					if (w_cnt) begin
						cnt       <= 8'h00;
						dir_dn    <= 1'b0;
						wave      <= 1'b0;
						per_act   <= per_buf;
						dty_act   <= dty_buf;
						zero_pend <= 1'b0;
					end else if (zero_pend && tick_src) begin
						cnt       <= 8'h00;
						zero_pend <= 1'b0;
					end else if (run) begin
						if (end_left) begin
							cnt     <= 8'h00;
							wave    <= 1'b0;
							per_act <= per_buf;
							dty_act <= dty_buf;
						end else if (end_ctr) begin
							cnt     <= 8'h00;
							dir_dn  <= 1'b0;
							wave    <= wave ^ dty_hit;
							per_act <= per_buf;
							dty_act <= dty_buf;
						end else begin
							cnt  <= nxt;
							wave <= wave ^ dty_hit;
							if (calign[i] && per_hit) begin
								dir_dn <= 1'b1;
							end
						end
					end
					// Disabling hands the buffered values to the active pair
					if (dis_edge) begin
						per_act <= per_buf;
						dty_act <= dty_buf;
					end
					if (w_per && !en) begin
						per_act <= wdata_q;
					end
					if (w_dty && !en) begin
						dty_act <= wdata_q;
					end
					// Period zero while idle clears the count on the next selected tick
					if (w_per && !en && (wdata_q == 8'h00)) begin
						zero_pend <= 1'b1;
					end
				end
			end
		end
	endgenerate

endmodule

// ==== logic/pwmct_cfg.svh ====
// Constants for the eight-channel PWM clock and channel timer core.
// Assumes an AXI4-Lite master with 32-bit data; register index times four
// gives the byte address.
`ifndef PWMCT_CFG_SVH
`define PWMCT_CFG_SVH

`define PWMCT_NCH          8
`define PWMCT_IDX_ENABLE   6'h00
`define PWMCT_IDX_POLARITY 6'h01
`define PWMCT_IDX_SCLSEL   6'h02
`define PWMCT_IDX_PRESC    6'h03
`define PWMCT_IDX_CALIGN   6'h04
`define PWMCT_IDX_CTRL     6'h05
`define PWMCT_IDX_ABSEL    6'h06
`define PWMCT_IDX_SCALE_A  6'h08
`define PWMCT_IDX_SCALE_B  6'h09
`define PWMCT_IDX_CNT      6'h0C
`define PWMCT_IDX_PER      6'h14
`define PWMCT_IDX_DTY      6'h1C
`define PWMCT_IDX_LAST     6'h23
`define PWMCT_RST_PER      8'hFF
`define PWMCT_RST_DTY      8'hFF
`define PWMCT_RST_ABSEL    8'hCC
`define PWMCT_RST_SCLSEL   8'h00
`define PWMCT_CTRL_FRZ     2
`define PWMCT_PRESC_A_LSB  0
`define PWMCT_PRESC_B_LSB  4
`define PWMCT_RESP_OKAY    2'h0
`define PWMCT_RESP_SLVERR  2'h2

`endif

// ==== logic/pwmct_pkg.sv ====
// Types shared by the PWM clock and channel timer core.
// Assumes nothing beyond the constants header.
package pwmct_pkg;
	typedef logic [7:0]  pwmct_byte_t;
	typedef logic [7:0]  pwmct_chan_t;
	typedef logic [7:0]  pwmct_addr_t;
	typedef logic [31:0] pwmct_word_t;
	typedef logic [1:0]  pwmct_resp_t;
endpackage

// ==== tb/pwmct_top_chk.sv ====
// Port-level checks for the PWM timer core, bound to its top module.
// Assumes one clock and the synchronous active-low reset; wstrb[0] gates writes.
`include "pwmct_cfg.svh"

module pwmct_top_chk (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic                   freeze_in,
	input wire pwmct_pkg::pwmct_addr_t awaddr,
	input wire logic                   awvalid,
	input wire logic                   awready,
	input wire pwmct_pkg::pwmct_word_t wdata,
	input wire logic [3:0]             wstrb,
	input wire logic                   wvalid,
	input wire logic                   wready,
	input wire logic                   bvalid,
	input wire pwmct_pkg::pwmct_addr_t araddr,
	input wire logic                   arvalid,
	input wire logic                   arready,
	input wire pwmct_pkg::pwmct_word_t rdata,
	input wire pwmct_pkg::pwmct_resp_t rresp,
	input wire logic                   rvalid,
	input wire pwmct_pkg::pwmct_chan_t pwm_out
);
	import pwmct_pkg::*;

	logic [7:0] aw_q;
	logic [7:0] w_q;
	logic [7:0] en_m;
	logic [7:0] pol_m;
	logic       ws_q;
	logic       b_q;
	logic       frz_m;
	wire  [5:0] wi     = aw_q[7:2];
	wire  [2:0] ci     = 3'(wi - `PWMCT_IDX_CNT);
	wire        upd    = bvalid && !b_q && ws_q;
	wire        cnt_wr = wi >= `PWMCT_IDX_CNT && wi < `PWMCT_IDX_PER;
	wire  [5:0] ri     = araddr[7:2];
	wire        ar_bad = ri == 6'h07 || ri == 6'h0A || ri == 6'h0B
		|| ri > `PWMCT_IDX_LAST;

	// Shadow copies lag the core by one edge, which the checks allow for
	always_ff @(posedge aclk) begin
		b_q <= bvalid && aresetn;
		if (awvalid && awready) aw_q <= awaddr;
		if (wvalid && wready) w_q <= wdata[7:0];
		if (wvalid && wready) ws_q <= wstrb[0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_m  <= 8'h00;
			pol_m <= 8'h00;
			frz_m <= 1'b0;
		end else if (upd) begin
			if (wi == `PWMCT_IDX_ENABLE) en_m <= w_q;
			if (wi == `PWMCT_IDX_POLARITY) pol_m <= w_q;
			if (wi == `PWMCT_IDX_CTRL) frz_m <= w_q[`PWMCT_CTRL_FRZ];
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_w_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_b_next;
		!bvalid ##1 bvalid;
	endsequence
	// Bus idle too, so no enable or counter write can move the outputs
	sequence s_frozen;
		(frz_m && freeze_in && awready && wready)[*8];
	endsequence

	chk_off_disabled: assert property ((pwm_out & ~en_m) == 8'h00)
		else $error("output high on a disabled channel");
	chk_freeze_hold: assert property (s_frozen |=> $stable(pwm_out))
		else $error("output moved while frozen");
	chk_cnt_restart: assert property (
		$rose(bvalid) && cnt_wr && ws_q && en_m[ci]
		|=> pwm_out[ci] == pol_m[ci])
		else $error("counter write did not restart at polarity level");
	chk_write_answer: assert property (s_w_taken |=> s_b_next)
		else $error("write response late or early");
	chk_b_blocks: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read data not returned next cycle");
	chk_read_unmapped: assert property (arvalid && arready && ar_bad
		|=> rresp == `PWMCT_RESP_SLVERR && rdata == 32'h00000000)
		else $error("unmapped read not refused");
	chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
endmodule

bind pwmct_top pwmct_top_chk u_chk (.*);

// ==== tb/pwmct_top_test.sv ====
// Self-checking bench for the PWM clock and channel timer core.
// Assumes the register map and bus timing of the core's constants header.
`include "pwmct_cfg.svh"

module pwmct_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pwmct_pkg::*;

	logic        aclk, aresetn, ce, freeze_in;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	pwmct_addr_t awaddr, araddr;
	pwmct_word_t wdata, rdata, ld;
	pwmct_resp_t bresp, rresp, lr;
	pwmct_chan_t pwm_out;
	logic [3:0]  wstrb;
	logic [7:0]  v;
	int          error_cnt, cmp_count, cyc;

	pwmct_top u_dut (.*);

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic end_sim;
		$display("mismatches %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic tmo;
		error_cnt++;
		$display("[FAIL] %0t wait ran out", $time);
		end_sim();
	endtask

	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		int n;
		awaddr  <= {i, 2'h0};
		wdata   <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		lr = bresp;
		bready <= 1'b0;
		if (n == 99) tmo();
		@(posedge aclk);
	endtask

	task automatic rd(input logic [5:0] i);
		int n;
		araddr  <= {i, 2'h0};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		ld = rdata;
		lr = rresp;
		rready <= 1'b0;
		if (n == 99) tmo();
		@(posedge aclk);
	endtask

	task automatic wt(input int c, input logic b);
		cyc = 0;
		while (pwm_out[c] !== b) begin
			@(posedge aclk);
			cyc++;
			if (cyc > 9999) tmo();
		end
	endtask

	// First cycle after any change may be irregular, so it is skipped
	task automatic meas(input int c, input int eh, input int ep);
		wt(c, 1'b0);
		wt(c, 1'b1);
		wt(c, 1'b0);
		wt(c, 1'b1);
		wt(c, 1'b0);
		chk(32'(cyc), 32'(eh));
		wt(c, 1'b1);
		chk(32'(cyc), 32'(ep - eh));
	endtask

	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		freeze_in = 1'b0;
		wstrb = 4'hF;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`PWMCT_IDX_ABSEL);
		chk(ld, 32'h000000CC);
		rd(`PWMCT_IDX_SCLSEL);
		chk(ld, 32'h00000000);
		for (int c = 0; c < 8; c++) begin
			rd(`PWMCT_IDX_PER + 6'(c));
			chk(ld, 32'h000000FF);
			rd(`PWMCT_IDX_DTY + 6'(c));
			chk(ld, 32'h000000FF);
			rd(`PWMCT_IDX_CNT + 6'(c));
			chk(ld, 32'h00000000);
		end
		rd(6'h07);
		chk(32'(lr), 32'(`PWMCT_RESP_SLVERR));
		wr(6'h0A, 8'h55);
		chk(32'(lr), 32'(`PWMCT_RESP_SLVERR));
		for (int c = 0; c < 3; c += 2) begin
			wr(`PWMCT_IDX_PER + 6'(c), 8'h04);
			wr(`PWMCT_IDX_DTY + 6'(c), 8'h01);
			wr(`PWMCT_IDX_CNT + 6'(c), 8'h00);
		end
		wr(`PWMCT_IDX_ENABLE, 8'h05);
		for (int f = 0; f < 8; f++) begin
			wr(`PWMCT_IDX_ENABLE, 8'h00);
			wr(`PWMCT_IDX_PRESC, {1'b0, 3'(7 - f), 1'b0, 3'(f)});
			wr(`PWMCT_IDX_ENABLE, 8'h05);
			meas(0, 3 << f, 4 << f);
			meas(2, 3 << (7 - f), 4 << (7 - f));
		end
		wr(`PWMCT_IDX_PRESC, 8'h00);
		wr(`PWMCT_IDX_POLARITY, 8'h01);
		meas(0, 1, 4);
		wr(`PWMCT_IDX_SCLSEL, 8'h05);
		wr(`PWMCT_IDX_SCALE_A, 8'h03);
		wr(`PWMCT_IDX_SCALE_B, 8'h01);
		meas(0, 6, 24);
		meas(2, 6, 8);
		wr(`PWMCT_IDX_SCALE_A, 8'h00);
		meas(0, 512, 2048);
		wr(`PWMCT_IDX_SCLSEL, 8'h00);
		wr(`PWMCT_IDX_ABSEL, 8'hCD);
		wr(`PWMCT_IDX_PRESC, 8'h20);
		meas(0, 4, 16);
		wr(`PWMCT_IDX_ABSEL, 8'hCC);
		wr(`PWMCT_IDX_PRESC, 8'h00);
		wr(`PWMCT_IDX_DTY, 8'h02);
		rd(`PWMCT_IDX_DTY);
		chk(ld, 32'h00000002);
		meas(0, 2, 4);
		wr(`PWMCT_IDX_PER, 8'h08);
		wr(`PWMCT_IDX_CNT, 8'h00);
		meas(0, 2, 8);
		wr(`PWMCT_IDX_PER, 8'hC8);
		wr(`PWMCT_IDX_CNT, 8'h00);
		repeat (60) @(posedge aclk);
		wr(`PWMCT_IDX_ENABLE, 8'h04);
		rd(`PWMCT_IDX_CNT);
		v = ld[7:0];
		chk(32'(v != 8'h00), 32'h00000001);
		repeat (20) @(posedge aclk);
		rd(`PWMCT_IDX_CNT);
		chk(ld, 32'(v));
		chk(32'(pwm_out[0]), 32'h00000000);
		wr(`PWMCT_IDX_PER, 8'h00);
		repeat (10) @(posedge aclk);
		rd(`PWMCT_IDX_CNT);
		chk(ld, 32'h00000000);
		wr(`PWMCT_IDX_PER, 8'hC8);
		wr(`PWMCT_IDX_CTRL, 8'h04);
		freeze_in <= 1'b1;
		wr(`PWMCT_IDX_ENABLE, 8'h05);
		repeat (10) @(posedge aclk);
		rd(`PWMCT_IDX_CNT);
		v = ld[7:0];
		repeat (30) @(posedge aclk);
		rd(`PWMCT_IDX_CNT);
		chk(ld, 32'(v));
		freeze_in <= 1'b0;
		repeat (30) @(posedge aclk);
		rd(`PWMCT_IDX_CNT);
		chk(32'(ld[7:0] != v), 32'h00000001);
		wr(`PWMCT_IDX_CALIGN, 8'h04);
		wr(`PWMCT_IDX_CNT + 6'h02, 8'h00);
		meas(2, 6, 8);
		ce <= 1'b0;
		@(posedge aclk);
		v = pwm_out;
		repeat (40) @(posedge aclk);
		chk(32'(pwm_out), 32'(v));
		ce <= 1'b1;
		wstrb <= 4'h0;
		wr(`PWMCT_IDX_POLARITY, 8'hFF);
		chk(32'(lr), 32'(`PWMCT_RESP_OKAY));
		wstrb <= 4'hF;
		rd(`PWMCT_IDX_POLARITY);
		chk(ld, 32'h00000001);
		end_sim();
	end
endmodule
